// *** shared/pcr_defs.vh ***
/*
 Constants for the chromaticity readback bank: command codes, link
 selectors, field positions and the coordinate width.
 Assumes it is included by bare name from the design files.
*/
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

`define PCR_CMD_LOW_PAIRS 8'h70
`define PCR_CMD_BLACK_X 8'h71
`define PCR_CMD_BLACK_Y 8'h72
`define PCR_CMD_WHITE_X 8'h73
`define PCR_COORD_W 10
`define PCR_UPPER_HI 9
`define PCR_UPPER_LO 2
`define PCR_LINK_SPI 1'b0
`define PCR_LINK_DSI 1'b1
`define PCR_ANS_ONE 2'h1
`define PCR_ANS_TWO 2'h2
`define PCR_DUMMY_BYTE 8'h00
`define PCR_COORD_RESET 10'h000

`endif

// *** src/pcr_coord_store.v ***
/*
 Holds the four 10-bit black and white coordinates and loads them from
 the device's calibration source.
 Assumes load strobes come from logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defs.vh"

module pcr_coord_store (
  input wire ref_clk,
  input wire rst_b,
  input wire load,
  input wire [1:0] load_sel,
  input wire [9:0] load_value,
  output reg [9:0] black_x_coord,
  output reg [9:0] black_y_coord,
  output reg [9:0] white_x_coord,
  output reg [9:0] white_y_coord
);

  // Content is undefined by contract; zero is just a deterministic fill
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      black_x_coord <= `PCR_COORD_RESET;
      black_y_coord <= `PCR_COORD_RESET;
      white_x_coord <= `PCR_COORD_RESET;
      white_y_coord <= `PCR_COORD_RESET;
    end else if (load) begin
      case (load_sel)
        2'h0: black_x_coord <= load_value;
        2'h1: black_y_coord <= load_value;
        2'h2: white_x_coord <= load_value;
        default: white_y_coord <= load_value;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** src/pcr_readback.v ***
/*
 Chromaticity readback bank: answers the four read commands with bytes
 built from the stored black and white coordinates.
 A dummy byte leads every answer except the upper-bit reads on DSI.
 Assumes the command decoder on ref_clk gives a one-cycle command strobe
 and pulls answer bytes with a one-cycle take strobe.
 Commands that arrive while an answer is pending are dropped silently.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defs.vh"

module pcr_readback (
  input wire ref_clk,
  input wire rst_b,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire link_sel,
  input wire [3:0] display_mode,
  input wire rd_take,
  input wire load,
  input wire [1:0] load_sel,
  input wire [9:0] load_value,
  output reg [7:0] rd_data,
  output wire rd_valid,
  output reg cmd_hit
);

  // Answer sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_FIRST = 2'h1;
  localparam ST_SECOND = 2'h2;

  wire [9:0] black_x_coord;
  wire [9:0] black_y_coord;
  wire [9:0] white_x_coord;
  wire [9:0] white_y_coord;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] held;
  reg [7:0] next_held;
  reg [7:0] next_rd_data;
  reg known;
  reg next_cmd_hit;
  wire take_cmd;
  wire [1:0] answer_len;
  wire [7:0] low_byte;

  // Recognises the four read codes that this bank answers
  function cmd_known;
    input [7:0] code;
    begin
      case (code)
        `PCR_CMD_LOW_PAIRS: cmd_known = 1'b1;
        `PCR_CMD_BLACK_X: cmd_known = 1'b1;
        `PCR_CMD_BLACK_Y: cmd_known = 1'b1;
        `PCR_CMD_WHITE_X: cmd_known = 1'b1;
        default: cmd_known = 1'b0;
      endcase
    end
  endfunction

  // Answer length in bytes; only DSI upper-bit reads drop the dummy
  function [1:0] byte_count;
    input [7:0] code;
    input link;
    begin
      if (link == `PCR_LINK_DSI && code != `PCR_CMD_LOW_PAIRS) begin
        byte_count = `PCR_ANS_ONE;
      end else begin
        byte_count = `PCR_ANS_TWO;
      end
    end
  endfunction

  // Packs the low two bits of each coordinate, black x in the top pair
  function [7:0] low_pairs;
    input [`PCR_COORD_W-1:0] bx;
    input [`PCR_COORD_W-1:0] by;
    input [`PCR_COORD_W-1:0] wx;
    input [`PCR_COORD_W-1:0] wy;
    begin
      low_pairs = {bx[1:0], by[1:0], wx[1:0], wy[1:0]};
    end
  endfunction

  // Upper eight bits of a coordinate
  function [7:0] upper_byte;
    input [9:0] coord;
    begin
      upper_byte = coord[`PCR_UPPER_HI:`PCR_UPPER_LO];
    end
  endfunction

  // Coordinate storage, filled through the calibration load port
  pcr_coord_store u_store (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .load(load),
    .load_sel(load_sel),
    .load_value(load_value),
    .black_x_coord(black_x_coord),
    .black_y_coord(black_y_coord),
    .white_x_coord(white_x_coord),
    .white_y_coord(white_y_coord)
  );

  // Mode input is deliberately unused for gating: reads always answer
  wire [3:0] unused_mode = display_mode;

  assign low_byte = low_pairs(black_x_coord, black_y_coord,
    white_x_coord, white_y_coord);
  assign take_cmd = cmd_valid && known && state == ST_IDLE;
  assign answer_len = byte_count(cmd_code, link_sel);

  always @* begin
    known = cmd_known(cmd_code);
    next_held = held;
    case (cmd_code)
      `PCR_CMD_LOW_PAIRS: next_held = low_byte;
      `PCR_CMD_BLACK_X: next_held = upper_byte(black_x_coord);
      `PCR_CMD_BLACK_Y: next_held = upper_byte(black_y_coord);
      `PCR_CMD_WHITE_X: next_held = upper_byte(white_x_coord);
      default: next_held = held;
    endcase
  end

  // Sequencer: dummy byte first on two-byte answers, then the data byte, each until taken
  always @* begin
    next_state = state;
    next_cmd_hit = take_cmd;
    case (state)
      ST_IDLE: begin
        if (take_cmd) begin
          if (answer_len == `PCR_ANS_ONE) begin
            next_state = ST_SECOND;
          end else begin
            next_state = ST_FIRST;
          end
        end
      end
      ST_FIRST: begin
        if (rd_take) begin
          next_state = ST_SECOND;
        end
      end
      ST_SECOND: begin
        if (rd_take) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Answer byte: stands unchanged until the host takes it
  always @* begin
    next_rd_data = rd_data;
    case (state)
      ST_IDLE: begin
        if (take_cmd && answer_len == `PCR_ANS_ONE) begin
          next_rd_data = next_held;
        end else if (take_cmd) begin
          next_rd_data = `PCR_DUMMY_BYTE;
        end
      end
      ST_FIRST: begin
        if (rd_take) begin
          next_rd_data = held;
        end
      end
      default: next_rd_data = rd_data;
    endcase
  end

  // Sequencer state register
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Answer byte register
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // Data byte is captured at acceptance so a later load cannot tear it
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      held <= 8'h00;
    end else if (take_cmd) begin
      held <= next_held;
    end
  end

  // Pulses one cycle after an accepted command
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_hit <= 1'b0;
    end else begin
      cmd_hit <= next_cmd_hit;
    end
  end

  assign rd_valid = (state != ST_IDLE);

endmodule
`default_nettype wire

// *** sim/pcr_props.sv ***
/* Checker for the readback bank ports.
 Assumes it is bound to pcr_readback. */
`timescale 1ns/1ps
`default_nettype none
module pcr_props (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic link_sel,
  input wire logic rd_take,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic cmd_hit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire known = cmd_code inside {[8'h70:8'h73]};
  wire go = cmd_valid && !rd_valid && known;
  a_hit_next: assert property (go |=> cmd_hit) else $error("no hit");
  a_hit_quiet: assert property (!go |=> !cmd_hit)
    else $error("stray hit");
  a_answer_next: assert property (go |=> rd_valid) else $error("late");
  a_dummy_first: assert property (go && (!link_sel || cmd_code == 8'h70)
    |=> rd_data == 8'h00) else $error("no dummy");
  a_dsi_single: assert property (go && link_sel && cmd_code != 8'h70
    ##1 rd_take |=> !rd_valid) else $error("extra byte");
  a_spi_pair: assert property (go && !link_sel ##1 rd_take
    |=> rd_valid) else $error("lost data byte");
  a_byte_holds: assert property (rd_valid && !rd_take |=>
    rd_valid && $stable(rd_data)) else $error("byte moved");
  a_drop_unknown: assert property (cmd_valid && !rd_valid && !known
    |=> !rd_valid) else $error("took unknown");
endmodule
bind pcr_readback pcr_props u_pcr_props (
  .ref_clk(ref_clk),
  .rst_b(rst_b),
  .cmd_valid(cmd_valid),
  .cmd_code(cmd_code),
  .link_sel(link_sel),
  .rd_take(rd_take),
  .rd_data(rd_data),
  .rd_valid(rd_valid),
  .cmd_hit(cmd_hit)
);
`default_nettype wire

// *** sim/pcr_host.sv ***
/* Host model: sends one read command and pulls every answer byte.
 Assumes calls come one at a time. */
`timescale 1ns/1ps
`default_nettype none
module pcr_host (
  input wire logic ref_clk,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic link_sel,
  output logic rd_take
);
  initial begin
    cmd_valid = 0;
    cmd_code = 8'h00;
    link_sel = 0;
    rd_take = 0;
  end
  task automatic read(input logic [7:0] c, input logic l,
      output int n, output logic [15:0] b);
    n = 0;
    b = 16'h0000;
    @(negedge ref_clk);
    cmd_valid = 1;
    cmd_code = c;
    link_sel = l;
    @(negedge ref_clk);
    cmd_valid = 0;
    cmd_code = ~c;
    repeat (3) begin
      if (rd_valid) begin
        b = {b[7:0], rd_data};
        n++;
      end
      rd_take = rd_valid;
      @(negedge ref_clk);
    end
    rd_take = 0;
  endtask
endmodule
`default_nettype wire

// *** sim/pcr_readback_bench.sv ***
/* Bench: loads coordinates, reads each code on both links.
 Assumes host model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pcr_readback_bench;
  logic ref_clk = 0, rst_b = 0, load = 0, cmd_valid, link_sel, rd_take;
  logic rd_valid, cmd_hit;
  logic [7:0] cmd_code, rd_data, e;
  logic [3:0] display_mode = 4'h0;
  logic [1:0] load_sel = 2'h0;
  logic [9:0] load_value = 10'h000;
  logic [9:0] crd [4] = '{10'h2B5, 10'h1CA, 10'h36F, 10'h0D2};
  logic [15:0] got;
  int mismatches = 0, cmp_count = 0, n;
  pcr_readback u_pcr_readback (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .link_sel(link_sel),
    .display_mode(display_mode),
    .rd_take(rd_take),
    .load(load),
    .load_sel(load_sel),
    .load_value(load_value),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .cmd_hit(cmd_hit)
  );
  pcr_host u_pcr_host (
    .ref_clk(ref_clk),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .link_sel(link_sel),
    .rd_take(rd_take)
  );
  initial forever #25 ref_clk = ~ref_clk;
  task automatic check(input logic [7:0] g, input logic [7:0] w);
    cmp_count++;
    if (g !== w) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, g, w);
    end
  endtask
  task automatic check_n(input int g, input int w);
    check(8'(g), 8'(w));
  endtask
  task automatic check_coord(input logic [9:0] g, input logic [9:0] w);
    cmp_count++;
    if (g !== w) begin
      mismatches++;
      $display("BAD %0t coord %h want %h", $time, g, w);
    end
  endtask
  task automatic load_coords;
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      load = 1;
      load_sel = 2'(i);
      load_value = crd[i];
    end
    @(negedge ref_clk);
    load = 0;
  endtask
  task automatic read_all;
    for (int k = 0; k < 8; k++) begin
      display_mode = 4'(k);
      e = k % 4 ? crd[k % 4 - 1][9:2]
        : {crd[0][1:0], crd[1][1:0], crd[2][1:0], crd[3][1:0]};
      u_pcr_host.read(8'(8'h70 + k % 4), 1'(k / 4), n, got);
      check_n(n, k > 4 ? 1 : 2);
      check(got[7:0], e);
      if (n == 2) check(got[15:8], 8'h00);
    end
  endtask
  task automatic refuse_unknown;
    u_pcr_host.read(8'h74, 1'b0, n, got);
    check_n(n, 0);
  endtask
  task automatic rebuild_coords;
    logic [7:0] low;
    u_pcr_host.read(8'h70, 1'b1, n, got);
    low = got[7:0];
    for (int i = 0; i < 3; i++) begin
      u_pcr_host.read(8'(8'h71 + i), 1'b1, n, got);
      check_coord({got[7:0], low[7 - 2 * i -: 2]}, crd[i]);
    end
  endtask
  task automatic reset_midway;
    fork
      u_pcr_host.read(8'h71, 1'b0, n, got);
      begin
        repeat (2) @(negedge ref_clk);
        rst_b = 0;
      end
    join
    check({7'h00, rd_valid}, 8'h00);
    check({7'h00, cmd_hit}, 8'h00);
    check(rd_data, 8'h00);
    repeat (2) @(negedge ref_clk);
    rst_b = 1;
    u_pcr_host.read(8'h71, 1'b1, n, got);
    check_n(n, 1);
  endtask
  task automatic final_report;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    rst_b = 1;
    load_coords;
    read_all;
    rebuild_coords;
    refuse_unknown;
    reset_midway;
    final_report;
  end
  initial begin
    #20000;
    mismatches++;
    final_report;
  end
endmodule
`default_nettype wire
